//--- rtl/cfg_link_if.sv
// Open-drain two-wire link joining host and device ends
`timescale 1ns/1ps
`default_nettype none
interface cfg_link_if;
   logic host_scl_o;
   logic host_scl_oe;
   logic host_sda_o;
   logic host_sda_oe;
   logic dev_sda_o;
   logic dev_sda_oe;
   logic scl;
   logic sda;

   // ************************************************************
   // Wired-AND with pull-up
   // ************************************************************
   assign scl = ~(host_scl_oe & ~host_scl_o);
   assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

   modport host (
      output host_scl_o,
      output host_scl_oe,
      output host_sda_o,
      output host_sda_oe,
      input  scl,
      input  sda
   );

   modport device (
      output dev_sda_o,
      output dev_sda_oe,
      input  scl,
      input  sda
   );
endinterface : cfg_link_if
`default_nettype wire

//--- rtl/cfg_link_pkg.sv
// Shared constants and types for the two-wire configuration port
package cfg_link_pkg;

   // ************************************************************
   // Bus addresses and fixed bytes
   // ************************************************************
   localparam logic [7:0] WR_ADDR        = 8'hd4;
   localparam logic [7:0] RD_ADDR        = 8'hd5;
   localparam logic [7:0] CMD_DUMMY      = 8'h00;
   localparam logic [7:0] WR_COUNT_DUMMY = 8'h08;

   // ************************************************************
   // Register file layout
   // ************************************************************
   localparam int         NUM_REGS       = 21;
   localparam logic [7:0] NUM_REGS_B     = 8'h15;
   localparam int         BYTE_COUNT_IDX = 8;
   localparam logic [7:0] COUNT_ZERO_RD  = 8'h0f;
   localparam int         HOST_RD_BYTES  = 8;
   localparam int         HOST_WR_BYTES  = 8;
   localparam logic [7:0] LAST_WR_STEP   = 8'h0a;
   // Byte 7 outputs on, byte 8 byte count zero, others zero
   localparam logic [NUM_REGS*8-1:0] REG_DEFAULT =
      {{12{8'h00}}, 8'h00, 8'hff, {7{8'h00}}};

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CLK_PERIOD_NS  = 20;
   localparam int SCL_PERIOD_NS  = 10000;
   localparam int QUARTER_CYC    =
      (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
   localparam logic [6:0] QUARTER_LAST = 7'(QUARTER_CYC - 1);

   // ************************************************************
   // State types
   // ************************************************************
   typedef enum logic [2:0] {
      D_IDLE = 3'b000,
      D_ADDR = 3'b001,
      D_ACK  = 3'b010,
      D_RX   = 3'b011,
      D_TX   = 3'b100,
      D_RACK = 3'b101
   } dev_state_t;

   typedef enum logic [1:0] {
      H_IDLE  = 2'b00,
      H_START = 2'b01,
      H_BIT   = 2'b10,
      H_STOP  = 2'b11
   } host_state_t;

endpackage : cfg_link_pkg

//--- rtl/cfg_port_device.sv
// Device end: two-wire slave holding the configuration bytes
`timescale 1ns/1ps
`default_nettype none
module cfg_port_device
   import cfg_link_pkg::*;
(
   input  wire logic                      link_clk,
   input  wire logic                      reset,
   cfg_link_if.device                     link,
   output logic      [NUM_REGS-1:0][7:0]  cfg
);

   // ************************************************************
   // Pin synchronisation and bus event detection
   // ************************************************************
   logic [1:0] pin_s;
   logic       scl_d;
   logic       sda_d;
   logic       scl_s;
   logic       sda_s;
   logic       start_c;
   logic       stop_c;
   logic       rise;
   logic       fall;

   sync_pair #(
      .WIDTH (2)
   ) u_pin_sync (
      .clk   (link_clk),
      .reset (reset),
      .d     ({link.scl, link.sda}),
      .q     (pin_s)
   );

   assign scl_s = pin_s[1];
   assign sda_s = pin_s[0];

   always_ff @(posedge link_clk) begin
      if (reset) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end

   // Data edges while the clock line stays high frame a transfer
   assign start_c = scl_s & scl_d & sda_d & ~sda_s;
   assign stop_c  = scl_s & scl_d & ~sda_d & sda_s;
   assign rise    = scl_s & ~scl_d;
   assign fall    = ~scl_s & scl_d;

   // ************************************************************
   // State
   // ************************************************************
   dev_state_t state;
   logic [3:0] bitcnt;
   logic [7:0] sh;
   logic [7:0] bnum;
   logic       is_read;
   logic       acked;
   logic       sda_oe;
   logic       sda_o;

   // ************************************************************
   // Read data selection
   // ************************************************************
   logic [7:0] eff_count;
   logic [7:0] rd_idx;
   logic [7:0] next_tx;
   logic       rd_done;

   always_comb begin
      if (cfg[BYTE_COUNT_IDX] == 8'h00) begin
         eff_count = COUNT_ZERO_RD;
      end else begin
         eff_count = cfg[BYTE_COUNT_IDX];
      end
   end

   assign rd_idx  = bnum - 8'h01;
   // Host has taken the counted number of data bytes
   assign rd_done = (bnum != 8'h00) && (rd_idx == eff_count);

   always_comb begin
      if (bnum == 8'h00) begin
         next_tx = eff_count;
      end else if (rd_idx < NUM_REGS_B) begin
         next_tx = cfg[rd_idx[4:0]];
      end else begin
         next_tx = 8'h00;
      end
   end

   // ************************************************************
   // Register file
   // ************************************************************
   logic [7:0] widx;
   logic       store;

   assign widx = bnum - 8'h02;

   // First two received bytes are command and count, dropped here
   assign store = (state == D_RX) && fall && (bitcnt == 4'h8)
                  && (bnum >= 8'h02) && (widx < NUM_REGS_B);

   always_ff @(posedge link_clk) begin
      if (reset) begin
         cfg <= REG_DEFAULT;
      end else if (store) begin
         cfg[widx[4:0]] <= sh;
      end
   end

   // ************************************************************
   // Protocol engine
   // ************************************************************
   always_ff @(posedge link_clk) begin
      if (reset) begin
         state   <= D_IDLE;
         bitcnt  <= 4'h0;
         sh      <= 8'h00;
         bnum    <= 8'h00;
         is_read <= 1'b0;
         acked   <= 1'b0;
         sda_oe  <= 1'b0;
      end else if (start_c) begin
         state  <= D_ADDR;
         bitcnt <= 4'h0;
         bnum   <= 8'h00;
         sda_oe <= 1'b0;
      end else if (stop_c) begin
         state  <= D_IDLE;
         sda_oe <= 1'b0;
      end else begin
         case (state)
            D_IDLE: begin
               sda_oe <= 1'b0;
            end
            D_ADDR: begin
               if (rise) begin
                  sh     <= {sh[6:0], sda_s};
                  bitcnt <= bitcnt + 4'h1;
               end else if (fall && bitcnt == 4'h8) begin
                  if (sh == WR_ADDR) begin
                     is_read <= 1'b0;
                     state   <= D_ACK;
                     sda_oe  <= 1'b1;
                  end else if (sh == RD_ADDR) begin
                     is_read <= 1'b1;
                     state   <= D_ACK;
                     sda_oe  <= 1'b1;
                  end else begin
                     state <= D_IDLE;
                  end
               end
            end
            D_ACK: begin
               if (fall) begin
                  bitcnt <= 4'h0;
                  if (is_read) begin
                     state  <= D_TX;
                     sh     <= next_tx;
                     sda_oe <= ~next_tx[7];
                     bnum   <= bnum + 8'h01;
                  end else begin
                     state  <= D_RX;
                     sda_oe <= 1'b0;
                  end
               end
            end
            D_RX: begin
               if (rise) begin
                  sh     <= {sh[6:0], sda_s};
                  bitcnt <= bitcnt + 4'h1;
               end else if (fall && bitcnt == 4'h8) begin
                  state  <= D_ACK;
                  sda_oe <= 1'b1;
                  if (bnum != 8'hff) begin
                     bnum <= bnum + 8'h01;
                  end
               end
            end
            D_TX: begin
               if (rise) begin
                  bitcnt <= bitcnt + 4'h1;
               end else if (fall) begin
                  if (bitcnt == 4'h8) begin
                     state  <= D_RACK;
                     sda_oe <= 1'b0;
                  end else begin
                     sh     <= {sh[6:0], 1'b0};
                     sda_oe <= ~sh[6];
                  end
               end
            end
            D_RACK: begin
               if (rise) begin
                  acked <= ~sda_s;
               end else if (fall) begin
                  bitcnt <= 4'h0;
                  if (acked && !rd_done) begin
                     state  <= D_TX;
                     sh     <= next_tx;
                     sda_oe <= ~next_tx[7];
                     bnum   <= bnum + 8'h01;
                  end else begin
                     // Release the line so the host can send stop
                     state <= D_IDLE;
                  end
               end
            end
            default: begin
               state  <= D_IDLE;
               sda_oe <= 1'b0;
            end
         endcase
      end
   end

   // ************************************************************
   // Pin drive
   // ************************************************************
   always_ff @(posedge link_clk) begin
      sda_o <= 1'b0;
   end

   assign link.dev_sda_o  = sda_o;
   assign link.dev_sda_oe = sda_oe;

endmodule : cfg_port_device
`default_nettype wire

//--- rtl/cfg_port_host.sv
// Host end: two-wire master issuing block writes and block reads
`timescale 1ns/1ps
`default_nettype none
module cfg_port_host
   import cfg_link_pkg::*;
(
   input  wire logic                           clk,
   input  wire logic                           reset,
   cfg_link_if.host                            link,
   input  wire logic                           wr_go,
   input  wire logic                           rd_go,
   input  wire logic [HOST_WR_BYTES-1:0][7:0]  wr_data,
   output logic                                busy,
   output logic                                done,
   output logic                                nack,
   output logic      [7:0]                     rd_count,
   output logic      [HOST_RD_BYTES-1:0][7:0]  rd_data
);

   // ************************************************************
   // Data line synchroniser and bit-rate divider
   // ************************************************************
   logic        sda_s;
   host_state_t state;
   logic [6:0]  qcnt;
   logic        tick;

   sync_pair #(
      .WIDTH (1)
   ) u_sda_sync (
      .clk   (clk),
      .reset (reset),
      .d     (link.sda),
      .q     (sda_s)
   );

   // Four quarters per bit keep the link at standard-mode rate
   assign tick = (qcnt == QUARTER_LAST);

   always_ff @(posedge clk) begin
      if (reset || state == H_IDLE) begin
         qcnt <= 7'h00;
      end else if (tick) begin
         qcnt <= 7'h00;
      end else begin
         qcnt <= qcnt + 7'h01;
      end
   end

   // ************************************************************
   // Transfer engine
   // ************************************************************
   logic [1:0]                     ph;
   logic [3:0]                     bitn;
   logic [7:0]                     step;
   logic [7:0]                     sidx;
   logic [7:0]                     sh;
   logic                           is_read;
   logic                           rx;
   logic                           ack_bad;
   logic                           scl_oe;
   logic                           sda_oe;
   logic                           pin_o;
   logic [HOST_WR_BYTES-1:0][7:0]  wbuf;

   assign sidx = step - 8'h02;

   always_ff @(posedge clk) begin
      if (reset) begin
         state    <= H_IDLE;
         ph       <= 2'h0;
         bitn     <= 4'h0;
         step     <= 8'h00;
         sh       <= 8'h00;
         is_read  <= 1'b0;
         rx       <= 1'b0;
         ack_bad  <= 1'b0;
         scl_oe   <= 1'b0;
         sda_oe   <= 1'b0;
         busy     <= 1'b0;
         done     <= 1'b0;
         nack     <= 1'b0;
         rd_count <= 8'h00;
         rd_data  <= '0;
         wbuf     <= '0;
      end else begin
         done <= 1'b0;
         case (state)
            H_IDLE: begin
               if (wr_go || rd_go) begin
                  is_read <= ~wr_go;
                  sh      <= wr_go ? WR_ADDR : RD_ADDR;
                  wbuf    <= wr_data;
                  state   <= H_START;
                  ph      <= 2'h0;
                  step    <= 8'h00;
                  rx      <= 1'b0;
                  busy    <= 1'b1;
                  nack    <= 1'b0;
               end
            end
            H_START: begin
               if (tick) begin
                  ph <= ph + 2'h1;
                  case (ph)
                     2'h1: sda_oe <= 1'b1;
                     2'h2: scl_oe <= 1'b1;
                     2'h3: begin
                        state <= H_BIT;
                        bitn  <= 4'h0;
                     end
                     default: ;
                  endcase
               end
            end
            H_BIT: begin
               if (tick) begin
                  ph <= ph + 2'h1;
                  case (ph)
                     2'h0: begin
                        if (rx) begin
                           sda_oe <= (bitn == 4'h8);
                        end else begin
                           sda_oe <= (bitn != 4'h8) && ~sh[7];
                        end
                     end
                     2'h1: scl_oe <= 1'b0;
                     2'h2: begin
                        if (rx && bitn != 4'h8) begin
                           sh <= {sh[6:0], sda_s};
                        end else if (!rx && bitn == 4'h8) begin
                           ack_bad <= sda_s;
                        end
                     end
                     default: begin
                        scl_oe <= 1'b1;
                        if (bitn != 4'h8) begin
                           bitn <= bitn + 4'h1;
                           if (!rx) begin
                              sh <= {sh[6:0], 1'b0};
                           end
                        end else begin
                           bitn <= 4'h0;
                           step <= step + 8'h01;
                           if (!rx && ack_bad) begin
                              nack  <= 1'b1;
                              state <= H_STOP;
                           end else if (!is_read) begin
                              if (step == LAST_WR_STEP) begin
                                 state <= H_STOP;
                              end else if (step == 8'h00) begin
                                 sh <= CMD_DUMMY;
                              end else if (step == 8'h01) begin
                                 sh <= WR_COUNT_DUMMY;
                              end else begin
                                 sh <= wbuf[sidx[2:0]];
                              end
                           end else begin
                              rx <= 1'b1;
                              if (step == 8'h01) begin
                                 rd_count <= sh;
                              end
                              if (step >= 8'h02 && sidx < 8'h08) begin
                                 rd_data[sidx[2:0]] <= sh;
                              end
                              if ((step == 8'h01 && sh == 8'h00) ||
                                  (step >= 8'h02 &&
                                   step - 8'h01 == rd_count)) begin
                                 state <= H_STOP;
                              end
                           end
                        end
                     end
                  endcase
               end
            end
            H_STOP: begin
               if (tick) begin
                  ph <= ph + 2'h1;
                  case (ph)
                     2'h0: sda_oe <= 1'b1;
                     2'h1: scl_oe <= 1'b0;
                     2'h2: sda_oe <= 1'b0;
                     default: begin
                        state <= H_IDLE;
                        busy  <= 1'b0;
                        done  <= 1'b1;
                     end
                  endcase
               end
            end
            default: state <= H_IDLE;
         endcase
      end
   end

   // ************************************************************
   // Pin drive
   // ************************************************************
   always_ff @(posedge clk) begin
      pin_o <= 1'b0;
   end

   assign link.host_scl_o  = pin_o;
   assign link.host_scl_oe = scl_oe;
   assign link.host_sda_o  = pin_o;
   assign link.host_sda_oe = sda_oe;

endmodule : cfg_port_host
`default_nettype wire

//--- rtl/sync_pair.sv
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none
module sync_pair #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta;

   always_ff @(posedge clk) begin
      if (reset) begin
         meta <= '1;
         q    <= '1;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule : sync_pair
`default_nettype wire

//--- testbench/cfg_link_assertions.sv
// Protocol checks on the two-wire link between host and device ends
`timescale 1ns/1ps
`default_nettype none
module cfg_link_assertions
   import cfg_link_pkg::*;
(
   input  wire logic link_clk,
   input  wire logic reset,
   input  wire logic host_sda_oe,
   input  wire logic dev_sda_oe,
   input  wire logic scl,
   input  wire logic sda
);
   // 10 us bit period on a 6 ns link clock, less margin
   localparam int MIN_GAP = 1600;
   logic        scl_q;
   logic        sda_q;
   logic [3:0]  bitn;
   logic [4:0]  byte_n;
   logic [7:0]  sh;
   logic [7:0]  addr;
   logic [7:0]  cnt_reg;
   logic [15:0] gap;
   wire         rise  = scl & ~scl_q;
   wire         start = scl & scl_q & sda_q & ~sda;
   wire         stop  = scl & scl_q & ~sda_q & sda;
   wire         ackb  = rise & (bitn == 4'h8);

   always_ff @(posedge link_clk) begin
      scl_q <= reset | scl;
      sda_q <= reset | sda;
   end

   always_ff @(posedge link_clk) begin
      if (reset || start) begin
         bitn   <= 4'h0;
         byte_n <= 5'h00;
      end else if (rise) begin
         bitn   <= (bitn == 4'h8) ? 4'h0 : bitn + 4'h1;
         byte_n <= byte_n + {4'h0, bitn == 4'h8};
      end
   end

   always_ff @(posedge link_clk) begin
      if (rise && bitn != 4'h8) begin
         sh <= {sh[6:0], sda};
      end
   end

   // Address of the transfer and the shadow of the count byte
   always_ff @(posedge link_clk) begin
      if (reset) begin
         addr    <= 8'h00;
         cnt_reg <= 8'h00;
      end else if (ackb && byte_n == 5'h00) begin
         addr <= sh;
      end else if (ackb && byte_n == 5'h0b && addr == WR_ADDR) begin
         cnt_reg <= sh;
      end
   end

   always_ff @(posedge link_clk) begin
      if (reset) begin
         gap <= 16'hffff;
      end else if (rise) begin
         gap <= 16'h0000;
      end else if (gap != 16'hffff) begin
         gap <= gap + 16'h0001;
      end
   end

   default clocking cb @(posedge link_clk); endclocking
   default disable iff (reset);

   property p_ack_wr;
      ackb && byte_n == 5'h00 && sh == WR_ADDR |-> !sda;
   endproperty
   a_ack_wr: assert property (p_ack_wr)
      else $error("write address not acknowledged");
   property p_ack_rd;
      ackb && byte_n == 5'h00 && sh == RD_ADDR |-> !sda;
   endproperty
   a_ack_rd: assert property (p_ack_rd)
      else $error("read address not acknowledged");
   property p_no_ack;
      ackb && byte_n == 5'h00 && sh != WR_ADDR && sh != RD_ADDR
         |-> !dev_sda_oe;
   endproperty
   a_no_ack: assert property (p_no_ack)
      else $error("foreign address acknowledged");
   property p_wr_bytes;
      ackb && byte_n != 5'h00 && addr == WR_ADDR |-> !sda;
   endproperty
   a_wr_bytes: assert property (p_wr_bytes)
      else $error("write byte not acknowledged");
   property p_rd_count;
      ackb && byte_n == 5'h01 && addr == RD_ADDR
         |-> sh == ((cnt_reg == 8'h00) ? COUNT_ZERO_RD : cnt_reg);
   endproperty
   a_rd_count: assert property (p_rd_count)
      else $error("wrong byte count sent");
   property p_host_ack;
      ackb && byte_n != 5'h00 && addr == RD_ADDR |-> !sda;
   endproperty
   a_host_ack: assert property (p_host_ack)
      else $error("read byte not acknowledged by host");
   property p_host_free;
      ackb && (byte_n == 5'h00 || addr == WR_ADDR) |-> !host_sda_oe;
   endproperty
   a_host_free: assert property (p_host_free)
      else $error("host drives data line in device acknowledge");
   // Stop follows the one clock rise that opens the next unit
   property p_units;
      stop |-> bitn == 4'h1;
   endproperty
   a_units: assert property (p_units)
      else $error("stop inside a unit");
   property p_rate;
      $rose(scl) |-> gap >= 16'(MIN_GAP);
   endproperty
   a_rate: assert property (p_rate)
      else $error("bit period too short");

   c_wr: cover property (ackb && byte_n == 5'h0a && addr == WR_ADDR);
   c_rd: cover property (ackb && byte_n == 5'h01 && addr == RD_ADDR);
   c_stop: cover property (stop);
endmodule : cfg_link_assertions
`default_nettype wire

//--- testbench/serial_config_block_port_tb.sv
// Self-checking bench joining the host and device ends
`timescale 1ns/1ps
`default_nettype none
module serial_config_block_port_tb
   import cfg_link_pkg::*;
;
   localparam int W = NUM_REGS * 8;
   typedef struct packed {
      logic        rd;
      logic [63:0] data;
   } row_t;
   localparam row_t ROWS [2] = '{
      '{1'b0, 64'h8001_7f80_c35a_a5ff},
      '{1'b1, 64'h8001_7f80_c35a_a5ff}};

   logic                          clk = 1'b0;
   logic                          link_clk = 1'b0;
   logic                          reset = 1'b1;
   logic                          wr_go = 1'b0;
   logic                          rd_go = 1'b0;
   logic [HOST_WR_BYTES-1:0][7:0] wr_data = '0;
   logic                          busy;
   logic                          done;
   logic                          nack;
   logic [7:0]                    rd_count;
   logic [HOST_RD_BYTES-1:0][7:0] rd_data;
   logic [NUM_REGS-1:0][7:0]      cfg;
   int                            error_cnt = 0;
   int                            check_count = 0;

   always #10 clk = ~clk;
   initial begin
      #1.3;
      forever #3 link_clk = ~link_clk;
   end

   cfg_link_if link ();
   cfg_port_host i_cfg_port_host (.clk(clk), .reset(reset), .link(link),
      .wr_go(wr_go), .rd_go(rd_go), .wr_data(wr_data), .busy(busy),
      .done(done), .nack(nack), .rd_count(rd_count), .rd_data(rd_data));
   cfg_port_device i_cfg_port_device (.link_clk(link_clk), .reset(reset),
      .link(link), .cfg(cfg));
   cfg_link_assertions i_cfg_link_assertions (.link_clk(link_clk),
      .reset(reset), .host_sda_oe(link.host_sda_oe),
      .dev_sda_oe(link.dev_sda_oe), .scl(link.scl), .sda(link.sda));

   task automatic check_val(input logic [W-1:0] got, input logic [W-1:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_val

   task automatic check_flag(input logic got, input logic exp);
      check_val(W'(got), W'(exp));
   endtask : check_flag

   task automatic summarize;
      if (error_cnt == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : summarize

   task automatic run(input logic rd, input logic [63:0] data);
      int n;
      @(posedge clk);
      #1;
      wr_go = ~rd;
      rd_go = rd;
      wr_data = data;
      @(posedge clk);
      #1;
      wr_go = 1'b0;
      rd_go = 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 100000) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n == 100000) begin
         error_cnt++;
         summarize();
      end
   endtask : run

   initial begin
      repeat (5) @(posedge clk);
      #1;
      reset = 1'b0;
      check_val(W'(cfg), W'(REG_DEFAULT));
      for (int i = 0; i < 2; i++) begin
         run(ROWS[i].rd, ROWS[i].data);
         check_flag(nack, 1'b0);
         if (ROWS[i].rd) begin
            check_val(W'(rd_count), W'(COUNT_ZERO_RD));
            check_val(W'(rd_data), W'(ROWS[i].data));
         end else begin
            check_val(W'(cfg[8:0]), W'({8'h00, ROWS[i].data}));
         end
      end
      // Reset in mid-read restores the defaults and frees the link
      @(posedge clk);
      #1;
      rd_go = 1'b1;
      @(posedge clk);
      #1;
      rd_go = 1'b0;
      check_flag(busy, 1'b1);
      // Device holds the line low through address ack and count bit 7
      repeat (5000) @(posedge clk);
      #1;
      check_flag(link.sda, 1'b0);
      reset = 1'b1;
      repeat (5) @(posedge clk);
      #1;
      reset = 1'b0;
      check_val(W'(cfg), W'(REG_DEFAULT));
      check_flag(busy, 1'b0);
      check_flag(link.sda, 1'b1);
      summarize();
   end
endmodule : serial_config_block_port_tb
`default_nettype wire
